// file: tcl_consts.svh
`ifndef TCL_CONSTS_SVH
`define TCL_CONSTS_SVH

// register byte offsets
`define TCL_OFS_CTRL      12'h000
`define TCL_OFS_STATUS    12'h004
`define TCL_OFS_CMD       12'h008
`define TCL_OFS_CODEC     12'h00c
`define TCL_OFS_FRAME_CNT 12'h010

// control register fields
`define TCL_CTRL_TCH_ACTIVE 0
`define TCL_CTRL_AUDIO_TEST 1
`define TCL_CTRL_SIM_PRESENT 2
`define TCL_CTRL_OPEN       3

// command register fields
`define TCL_CMD_LOOP_LSB 0
`define TCL_CMD_LOOP_MSB 1
`define TCL_CMD_CHAN_LSB 4
`define TCL_CMD_CHAN_MSB 6
`define TCL_CMD_GO       8

// frame sizes in bits
`define TCL_BITS_FR   10'd260
`define TCL_BITS_EFR  10'd244
`define TCL_BITS_HR   10'd112
`define TCL_BITS_SIDP 10'd35
`define TCL_BITS_BURST 10'd114

`define TCL_FRAME_W 10'd320
`define TCL_AXI_OKAY   2'h0
`define TCL_AXI_SLVERR 2'h2

`endif

// file: tcl_pkg.sv
package tcl_pkg;

  typedef enum logic [2:0]
  {
    TCL_CH_FR   = 3'h0,
    TCL_CH_EFR  = 3'h1,
    TCL_CH_HR   = 3'h2,
    TCL_CH_AFS  = 3'h3,
    TCL_CH_AHS  = 3'h4
  } tcl_chan_t;

  typedef enum logic [1:0]
  {
    TCL_LOOP_FRAME = 2'h0,
    TCL_LOOP_BURST = 2'h1
  } tcl_loop_t;

  // downlink receive classification from the decoder
  typedef enum logic [3:0]
  {
    TCL_RX_SPEECH_GOOD = 4'h0,
    TCL_RX_SPEECH_BAD  = 4'h1,
    TCL_RX_SID_UPDATE  = 4'h2,
    TCL_RX_SID_BAD     = 4'h3,
    TCL_RX_SID_FIRST   = 4'h4,
    TCL_RX_SID_FIRST_P2 = 4'h5,
    TCL_RX_SID_INH     = 4'h6,
    TCL_RX_ONSET       = 4'h7,
    TCL_RX_NO_DATA     = 4'h8,
    TCL_RX_RATS        = 4'h9,
    TCL_RX_RATS_BAD    = 4'ha,
    TCL_RX_FACCH       = 4'hb,
    TCL_RX_USER_DATA   = 4'hc
  } tcl_rx_t;

  typedef enum logic [2:0]
  {
    TCL_ST_OPEN   = 3'b001,
    TCL_ST_FRAME  = 3'b010,
    TCL_ST_BURST  = 3'b100
  } tcl_state_t;

endpackage : tcl_pkg

// file: tcl_loop.sv
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`include "tcl_consts.svh"

module tcl_loop
(
  input  wire logic         aclk,           // system clock
  input  wire logic         aresetn,        // synchronous reset, low
  input  wire logic [11:0]  s_axi_awaddr,   // write address
  input  wire logic         s_axi_awvalid,  // write address valid
  output logic              s_axi_awready,  // write address ready
  input  wire logic [31:0]  s_axi_wdata,    // write data
  input  wire logic [3:0]   s_axi_wstrb,    // write strobes
  input  wire logic         s_axi_wvalid,   // write data valid
  output logic              s_axi_wready,   // write data ready
  output logic [1:0]        s_axi_bresp,    // write response
  output logic              s_axi_bvalid,   // write response valid
  input  wire logic         s_axi_bready,   // write response ready
  input  wire logic [11:0]  s_axi_araddr,   // read address
  input  wire logic         s_axi_arvalid,  // read address valid
  output logic              s_axi_arready,  // read address ready
  output logic [31:0]       s_axi_rdata,    // read data
  output logic [1:0]        s_axi_rresp,    // read response
  output logic              s_axi_rvalid,   // read data valid
  input  wire logic         s_axi_rready,   // read data ready
  input  wire logic         dl_valid,       // downlink frame strobe
  input  wire logic [319:0] dl_data,        // decoded bits, bit 0 first
  input  wire logic [9:0]   dl_nbits,       // adaptive decoded length
  input  wire logic [3:0]   dl_rx_type,     // receive classification
  input  wire logic [1:0]   dl_mode,        // decoder codec mode
  input  wire logic         dl_burst_valid, // burst strobe
  input  wire logic [113:0] dl_burst,       // decrypted burst bits
  input  wire logic         dl_burst_sacch, // burst is slow signalling
  input  wire logic         dl_burst_idle,  // burst is idle
  input  wire logic [1:0]   dl_cmd_mode,    // downlink codec mode command
  input  wire logic         dl_rats_msg,    // rate signalling message seen
  output logic              loop_close_acknowledge, // ack pulse
  output logic              loop_closed,    // loop state
  output logic              ul_valid,       // uplink frame strobe
  output logic [319:0]      ul_data,        // uplink frame bits
  output logic [9:0]        ul_nbits,       // uplink bit count
  output logic              ul_speech_good, // transmit type good speech
  output logic [1:0]        ul_cmi,         // uplink mode indication
  output logic [1:0]        ul_cmr,         // uplink mode request field
  output logic              ul_burst_valid, // uplink burst strobe
  output logic [113:0]      ul_burst,       // uplink burst bits
  output logic              rats_enable,    // rate signalling protocol on
  output logic [1:0]        enc_mode        // normal encoder codec mode
);

  // ************************************************************
  // register slave
  // ************************************************************
  logic [3:0]          ctrl_reg;
  logic [8:0]          cmd_reg;
  logic                cmd_go_reg;
  logic [31:0]         frame_cnt_reg;
  logic [31:0]         drop_cnt_reg;
  logic [11:0]         awaddr_reg;
  logic                aw_have_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic                w_have_reg;
  logic                acs_multi_reg;
  tcl_pkg::tcl_state_t state_reg;
  tcl_pkg::tcl_chan_t  chan_reg;
  logic [1:0]          prev_mode_reg;
  logic                pend_reg;
  logic [34:0]         pend_bits_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [11:0] a);
    return a == `TCL_OFS_CTRL || a == `TCL_OFS_STATUS || a == `TCL_OFS_CMD
           || a == `TCL_OFS_CODEC || a == `TCL_OFS_FRAME_CNT;
  endfunction : mapped

  wire wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  logic [31:0] wmerge_cmd;
  logic [31:0] wmerge_ctrl;
  logic [31:0] wmerge_codec;
  assign wmerge_cmd   = merge({23'h0, cmd_reg}, wdata_reg, wstrb_reg);
  assign wmerge_ctrl  = merge({28'h0, ctrl_reg}, wdata_reg, wstrb_reg);
  assign wmerge_codec = merge({31'h0, acs_multi_reg}, wdata_reg, wstrb_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 12'h000;
      wdata_reg     <= 32'h0;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TCL_AXI_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_reg) ? `TCL_AXI_OKAY : `TCL_AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // software control bits; the go bit is a self-clearing pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg      <= 4'h0;
      cmd_reg       <= 9'h000;
      cmd_go_reg    <= 1'b0;
      acs_multi_reg <= 1'b0;
    end
    else
    begin
      cmd_go_reg <= 1'b0;
      if (wr_fire && awaddr_reg == `TCL_OFS_CTRL)
        ctrl_reg <= wmerge_ctrl[3:0];
      else
        ctrl_reg[`TCL_CTRL_OPEN] <= 1'b0;
      if (wr_fire && awaddr_reg == `TCL_OFS_CMD)
      begin
        cmd_reg    <= wmerge_cmd[8:0];
        cmd_go_reg <= wmerge_cmd[`TCL_CMD_GO];
      end
      if (wr_fire && awaddr_reg == `TCL_OFS_CODEC)
        acs_multi_reg <= wmerge_codec[0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `TCL_AXI_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? `TCL_AXI_OKAY : `TCL_AXI_SLVERR;
        case (s_axi_araddr)
          `TCL_OFS_CTRL:      s_axi_rdata <= {28'h0, ctrl_reg};
          `TCL_OFS_STATUS:    s_axi_rdata <= {drop_cnt_reg[23:0], 1'b0, state_reg,
                                              1'b0, chan_reg};
          `TCL_OFS_CMD:       s_axi_rdata <= {23'h0, 1'b0, cmd_reg[7:0]};
          `TCL_OFS_CODEC:     s_axi_rdata <= {28'h0, prev_mode_reg, 1'b0, acs_multi_reg};
          `TCL_OFS_FRAME_CNT: s_axi_rdata <= frame_cnt_reg;
          default:            s_axi_rdata <= 32'h0;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // loop state
  // ************************************************************
  wire tch_active  = ctrl_reg[`TCL_CTRL_TCH_ACTIVE];
  wire audio_test  = ctrl_reg[`TCL_CTRL_AUDIO_TEST];
  wire sim_present = ctrl_reg[`TCL_CTRL_SIM_PRESENT];
  wire open_req    = ctrl_reg[`TCL_CTRL_OPEN] || !sim_present;
  // closing while the audio test runs would violate mutual exclusion
  wire close_ok    = tch_active && !audio_test && state_reg == tcl_pkg::TCL_ST_OPEN;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg              <= tcl_pkg::TCL_ST_OPEN;
      chan_reg               <= tcl_pkg::TCL_CH_FR;
      loop_close_acknowledge <= 1'b0;
      drop_cnt_reg           <= 32'h0;
    end
    else
    begin
      loop_close_acknowledge <= 1'b0;
      case (state_reg)
        tcl_pkg::TCL_ST_OPEN:
          if (cmd_go_reg && close_ok)
          begin
            chan_reg <= tcl_pkg::tcl_chan_t'(cmd_reg[`TCL_CMD_CHAN_MSB:`TCL_CMD_CHAN_LSB]);
            loop_close_acknowledge <= 1'b1;
            state_reg <= (cmd_reg[`TCL_CMD_LOOP_MSB:`TCL_CMD_LOOP_LSB] ==
                          tcl_pkg::TCL_LOOP_BURST) ? tcl_pkg::TCL_ST_BURST
                                                   : tcl_pkg::TCL_ST_FRAME;
          end
          else if (cmd_go_reg)
            drop_cnt_reg <= drop_cnt_reg + 32'h1;
        tcl_pkg::TCL_ST_FRAME, tcl_pkg::TCL_ST_BURST:
        begin
          if (cmd_go_reg)
            drop_cnt_reg <= drop_cnt_reg + 32'h1;
          if (open_req || !tch_active)
            state_reg <= tcl_pkg::TCL_ST_OPEN;
        end
        default: state_reg <= tcl_pkg::TCL_ST_OPEN;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      loop_closed <= 1'b0;
      rats_enable <= 1'b1;
    end
    else
    begin
      loop_closed <= state_reg != tcl_pkg::TCL_ST_OPEN;
      rats_enable <= state_reg == tcl_pkg::TCL_ST_OPEN;
    end
  end

  // normal encoder mode follows commands while the loop is open, or at any time while acs_multi_reg is clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      enc_mode <= 2'h0;
    else if (state_reg == tcl_pkg::TCL_ST_OPEN || !acs_multi_reg)
      enc_mode <= dl_cmd_mode;
  end

  // ************************************************************
  // frame substitution
  // ************************************************************
  wire looping  = state_reg == tcl_pkg::TCL_ST_FRAME;
  wire adaptive = chan_reg == tcl_pkg::TCL_CH_AFS || chan_reg == tcl_pkg::TCL_CH_AHS;
  wire half     = chan_reg == tcl_pkg::TCL_CH_AHS;
  tcl_pkg::tcl_rx_t rx;
  assign rx = tcl_pkg::tcl_rx_t'(dl_rx_type);

  function automatic logic [9:0] fixed_len(input tcl_pkg::tcl_chan_t c);
    case (c)
      tcl_pkg::TCL_CH_EFR: return `TCL_BITS_EFR;
      tcl_pkg::TCL_CH_HR:  return `TCL_BITS_HR;
      default:             return `TCL_BITS_FR;
    endcase
  endfunction : fixed_len

  logic       emit;
  logic       zero;
  logic       sid35;
  logic       two;
  logic       keep_mode;
  logic [319:0] mask;
  always_comb
  begin
    emit = 1'b0;
    zero = 1'b0;
    sid35 = 1'b0;
    two = 1'b0;
    keep_mode = 1'b0;
    for (int i = 0; i < 320; i++)
      mask[i] = 10'(i) < (adaptive ? dl_nbits : fixed_len(chan_reg));
    case (rx)
      tcl_pkg::TCL_RX_SPEECH_GOOD, tcl_pkg::TCL_RX_USER_DATA: emit = 1'b1;
      tcl_pkg::TCL_RX_SPEECH_BAD: begin emit = 1'b1; zero = 1'b1; end
      tcl_pkg::TCL_RX_FACCH: emit = 1'b0;
      tcl_pkg::TCL_RX_SID_UPDATE, tcl_pkg::TCL_RX_RATS:
      begin
        emit = adaptive; sid35 = 1'b1; two = half; keep_mode = 1'b1;
      end
      tcl_pkg::TCL_RX_SID_BAD, tcl_pkg::TCL_RX_RATS_BAD:
      begin
        emit = adaptive; zero = 1'b1; two = half; keep_mode = 1'b1;
      end
      tcl_pkg::TCL_RX_ONSET, tcl_pkg::TCL_RX_SID_FIRST, tcl_pkg::TCL_RX_NO_DATA:
      begin
        emit = adaptive; zero = 1'b1; keep_mode = rx != tcl_pkg::TCL_RX_ONSET;
      end
      tcl_pkg::TCL_RX_SID_FIRST_P2, tcl_pkg::TCL_RX_SID_INH:
      begin
        emit = half; zero = 1'b1; keep_mode = 1'b1;
      end
      default: emit = 1'b0;
    endcase
  end

  wire [1:0] ul_mode = (keep_mode || !acs_multi_reg) ? prev_mode_reg : dl_mode;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ul_valid       <= 1'b0;
      ul_data        <= 320'h0;
      ul_nbits       <= 10'h000;
      ul_speech_good <= 1'b0;
      ul_cmi         <= 2'h0;
      ul_cmr         <= 2'h0;
      prev_mode_reg  <= 2'h0;
      pend_reg       <= 1'b0;
      pend_bits_reg  <= 35'h0;
      frame_cnt_reg  <= 32'h0;
    end
    else
    begin
      ul_valid <= 1'b0;
      if (looping && pend_reg)
      begin
        // second half-rate frame carries parameters held back one clock cycle
        pend_reg <= 1'b0;
        ul_valid <= 1'b1;
        ul_data  <= {285'h0, pend_bits_reg};
      end
      else if (looping && dl_valid && emit)
      begin
        ul_valid       <= 1'b1;
        ul_nbits       <= adaptive ? dl_nbits : fixed_len(chan_reg);
        ul_speech_good <= adaptive;
        ul_cmi         <= ul_mode;
        ul_cmr         <= ul_mode;
        prev_mode_reg  <= ul_mode;
        frame_cnt_reg  <= frame_cnt_reg + 32'h1;
        if (zero || (sid35 && two))
          ul_data <= 320'h0;
        else if (sid35)
          ul_data <= {285'h0, dl_data[34:0]};
        else
          ul_data <= dl_data & mask;
        pend_reg      <= two;
        pend_bits_reg <= (sid35 && !zero) ? dl_data[34:0] : 35'h0;
      end
    end
  end

  // ************************************************************
  // burst loop
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ul_burst_valid <= 1'b0;
      ul_burst       <= 114'h0;
    end
    else
    begin
      ul_burst_valid <= state_reg == tcl_pkg::TCL_ST_BURST && dl_burst_valid
                        && !dl_burst_sacch && !dl_burst_idle;
      if (dl_burst_valid)
        ul_burst <= dl_burst;
    end
  end

endmodule : tcl_loop

// file: tcl_loop_props.sv
module tcl_loop_props
(
  input wire logic         aclk,                   // clock
  input wire logic         aresetn,                // reset, low
  input wire logic         dl_valid,               // frame in
  input wire logic [3:0]   dl_rx_type,             // rx class
  input wire logic         dl_burst_valid,         // burst in
  input wire logic [113:0] dl_burst,               // burst bits
  input wire logic         dl_burst_sacch,         // slow burst
  input wire logic         dl_burst_idle,          // idle burst
  input wire logic         loop_close_acknowledge, // ack
  input wire logic         loop_closed,            // loop state
  input wire logic         ul_valid,               // frame out
  input wire logic [319:0] ul_data,                // frame bits
  input wire logic [1:0]   ul_cmi,                 // indication
  input wire logic [1:0]   ul_cmr,                 // request
  input wire logic         ul_burst_valid,         // burst out
  input wire logic [113:0] ul_burst,               // burst bits
  input wire logic         rats_enable             // rate protocol
);
  // ****************************************
  // properties
  // ****************************************
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_ack_close;
    loop_close_acknowledge |-> !loop_closed ##1 loop_closed;
  endproperty
  a_ack_close: assert property (p_ack_close) else $error("ack without close");
  property p_no_reack;
    loop_closed |-> !loop_close_acknowledge;
  endproperty
  a_no_reack: assert property (p_no_reack) else $error("ack while closed");
  property p_ul_closed;
    ul_valid |-> $past(loop_closed) && ($past(dl_valid) || $past(ul_valid));
  endproperty
  a_ul_closed: assert property (p_ul_closed) else $error("uplink without cause");
  property p_zero;
    ul_valid && $past(dl_valid) && $past(dl_rx_type) inside {tcl_pkg::TCL_RX_SPEECH_BAD,
      tcl_pkg::TCL_RX_ONSET, tcl_pkg::TCL_RX_NO_DATA, tcl_pkg::TCL_RX_SID_BAD,
      tcl_pkg::TCL_RX_RATS_BAD, tcl_pkg::TCL_RX_SID_FIRST_P2, tcl_pkg::TCL_RX_SID_INH}
      |-> ul_data == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("erased frame not zero");
  property p_first35;
    ul_valid && $past(dl_valid) && $past(dl_rx_type) inside {tcl_pkg::TCL_RX_SID_UPDATE,
      tcl_pkg::TCL_RX_RATS} |-> ul_data[319:35] == '0;
  endproperty
  a_first35: assert property (p_first35) else $error("bits above 35 set");
  property p_inband;
    ul_valid |-> ul_cmi == ul_cmr;
  endproperty
  a_inband: assert property (p_inband) else $error("request differs");
  property p_burst_skip;
    ul_burst_valid |-> $past(dl_burst_valid) && !$past(dl_burst_sacch) && !$past(dl_burst_idle);
  endproperty
  a_burst_skip: assert property (p_burst_skip) else $error("burst looped wrongly");
  property p_burst_data;
    ul_burst_valid |-> ul_burst == $past(dl_burst);
  endproperty
  a_burst_data: assert property (p_burst_data) else $error("burst bits differ");
  property p_rats;
    loop_closed && $past(loop_closed) |-> !rats_enable;
  endproperty
  a_rats: assert property (p_rats) else $error("rate protocol on");
  c_ack: cover property (loop_close_acknowledge);
  c_pair: cover property (ul_valid ##1 ul_valid);
  c_burst: cover property (ul_burst_valid);
endmodule : tcl_loop_props

bind tcl_loop tcl_loop_props u_props (.*);

// file: tcl_dl_src.sv
module tcl_dl_src
(
  input  wire logic    aclk,           // clock
  output logic         dl_valid,       // frame strobe
  output logic [319:0] dl_data,        // decoded bits
  output logic [9:0]   dl_nbits,       // decoded length
  output logic [3:0]   dl_rx_type,     // rx class
  output logic [1:0]   dl_mode,        // decode mode
  output logic         dl_burst_valid, // burst strobe
  output logic [113:0] dl_burst,       // burst bits
  output logic         dl_burst_sacch, // slow burst
  output logic         dl_burst_idle,  // idle burst
  output logic [1:0]   dl_cmd_mode,    // mode command
  output logic         dl_rats_msg     // rate message
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {dl_valid, dl_data, dl_nbits, dl_rx_type, dl_mode} = '0;
    {dl_burst_valid, dl_burst, dl_burst_sacch, dl_burst_idle, dl_cmd_mode, dl_rats_msg} = '0;
  end
  task send_frame(input logic [3:0] t, input logic [1:0] m, input logic [9:0] n,
    input logic [319:0] d);
    @(posedge aclk);
    dl_valid   <= 1'b1;
    dl_rx_type <= t;
    dl_mode    <= m;
    dl_nbits   <= n;
    dl_data    <= d;
    @(posedge aclk);
    dl_valid <= 1'b0;
    // stale bits must never pass for a fresh frame
    dl_data  <= ~d;
  endtask : send_frame
  task send_burst(input logic [113:0] b, input logic s, input logic i);
    @(posedge aclk);
    dl_burst_valid <= 1'b1;
    dl_burst       <= b;
    dl_burst_sacch <= s;
    dl_burst_idle  <= i;
    @(posedge aclk);
    dl_burst_valid <= 1'b0;
    dl_burst       <= ~b;
  endtask : send_burst
  task set_cmd(input logic [1:0] m, input logic r);
    @(posedge aclk);
    dl_cmd_mode <= m;
    dl_rats_msg <= r;
  endtask : set_cmd
endmodule : tcl_dl_src

// file: testbench.sv
`include "tcl_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic dl_valid, dl_rats_msg, dl_burst_valid, dl_burst_sacch, dl_burst_idle, loop_closed;
  logic loop_close_acknowledge, ul_valid, ul_speech_good, ul_burst_valid, rats_enable;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, dl_rx_type;
  logic [1:0] s_axi_bresp, s_axi_rresp, dl_mode, dl_cmd_mode, ul_cmi, ul_cmr, enc_mode, r;
  logic [319:0] dl_data, ul_data;
  logic [9:0] dl_nbits, ul_nbits;
  logic [113:0] dl_burst, ul_burst;
  logic [334:0] ulq[$];
  logic [113:0] bq[$];
  int fail_count, tests_run, acks;
  localparam logic [319:0] pat = {10{32'hc3a5_e196}};
  logic [9:0] nb[3] = '{`TCL_BITS_FR, `TCL_BITS_EFR, `TCL_BITS_HR};
  logic [3:0] zl[5] = '{tcl_pkg::TCL_RX_ONSET, tcl_pkg::TCL_RX_SID_FIRST, tcl_pkg::TCL_RX_NO_DATA,
    tcl_pkg::TCL_RX_SID_BAD, tcl_pkg::TCL_RX_RATS_BAD};
  logic [3:0] sl[2] = '{tcl_pkg::TCL_RX_SID_UPDATE, tcl_pkg::TCL_RX_RATS};

  tcl_loop uut (.*);
  tcl_dl_src src (.*);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    if (loop_close_acknowledge === 1'b1)
      acks++;
    if (ul_valid === 1'b1)
      ulq.push_back({ul_speech_good, ul_cmr, ul_cmi, ul_nbits, ul_data});
    if (ul_burst_valid === 1'b1)
      bq.push_back(ul_burst);
  end
  // ****************************************
  // tasks
  // ****************************************
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task fail(input string m);
    fail_count++;
    $display("ERROR %0t %s", $time, m);
  endtask : fail
  task chk32(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
      fail($sformatf("got %h expected %h", g, e));
  endtask : chk32
  task chk_ul(input logic [319:0] e, input logic [9:0] n, input logic [1:0] m, input bit a);
    logic [334:0] u;
    tests_run++;
    if (ulq.size() == 0)
      fail("uplink frame missing");
    else
    begin
      u = ulq.pop_front();
      if (u[319:0] !== e || (n != 0 && u[329:320] !== n)
          || (a && u[334:330] !== {1'b1, m, m}))
        fail($sformatf("uplink frame n %0d mode %h", u[329:320], u[331:330]));
    end
  endtask : chk_ul
  task chk_b(input logic [113:0] e);
    tests_run++;
    if (bq.size() == 0 || bq.pop_front() !== e)
      fail("uplink burst wrong");
  endtask : chk_b
  function automatic logic [319:0] msk(input int n);
    msk = '0;
    for (int i = 0; i < n; i++)
      msk[i] = 1'b1;
  endfunction : msk
  task axi_wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    repeat (50)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    fail("write timeout");
    report_and_stop();
  endtask : axi_wr
  task axi_rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    repeat (50)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    fail("read timeout");
    report_and_stop();
  endtask : axi_rd
  task close_loop(input logic [1:0] lt, input logic [2:0] ch, input bit ok);
    int a0;
    a0 = acks;
    axi_wr(`TCL_OFS_CMD, {23'h0, 1'b1, 1'b0, ch, 2'b00, lt});
    // supervision window for the acknowledge
    repeat (8) @(posedge aclk);
    chk32(acks - a0, ok);
  endtask : close_loop
  task frm(input logic [3:0] t, input logic [1:0] m, input logic [9:0] n, input logic [319:0] v);
    src.send_frame(t, m, n, v);
    repeat (3) @(posedge aclk);
  endtask : frm
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`TCL_OFS_STATUS);
    chk32(d, 32'h10);
    chk32({rats_enable, loop_closed}, 2'b10);
    axi_rd(12'h020);
    chk32({r, d[29:0]}, {`TCL_AXI_SLVERR, 30'h0});
    $display("test reset done");
    close_loop(2'h0, 3'h0, 1'b0);
    axi_wr(`TCL_OFS_CTRL, 32'h7);
    close_loop(2'h0, 3'h0, 1'b0);
    axi_rd(`TCL_OFS_STATUS);
    chk32(d, 32'h210);
    $display("test refusal done");
    for (int c = 0; c < 3; c++)
    begin
      axi_wr(`TCL_OFS_CTRL, 32'h5);
      close_loop(2'h0, c[2:0], 1'b1);
      axi_rd(`TCL_OFS_STATUS);
      chk32(d, ((2 + c) << 8) | 32'h20 | c);
      frm(tcl_pkg::TCL_RX_SPEECH_GOOD, 2'h0, 10'd300, pat);
      chk_ul(pat & msk(nb[c]), nb[c], 2'h0, 1'b0);
      frm(tcl_pkg::TCL_RX_USER_DATA, 2'h0, 10'd300, ~pat);
      chk_ul(~pat & msk(nb[c]), nb[c], 2'h0, 1'b0);
      frm(tcl_pkg::TCL_RX_SPEECH_BAD, 2'h0, 10'd300, pat);
      chk_ul('0, 10'd0, 2'h0, 1'b0);
      frm(tcl_pkg::TCL_RX_FACCH, 2'h0, 10'd300, pat);
      chk32(ulq.size(), 0);
      close_loop(2'h0, c[2:0], 1'b0);
      axi_wr(`TCL_OFS_CTRL, 32'hd);
      repeat (3) @(posedge aclk);
      chk32(loop_closed, 1'b0);
    end
    $display("test fixed rate done");
    axi_wr(`TCL_OFS_CODEC, 32'h1);
    close_loop(2'h0, 3'h3, 1'b1);
    src.set_cmd(2'h3, 1'b1);
    frm(tcl_pkg::TCL_RX_SPEECH_GOOD, 2'h2, 10'd204, pat);
    chk_ul(pat & msk(204), 10'd204, 2'h2, 1'b1);
    chk32(enc_mode, 2'h0);
    frm(tcl_pkg::TCL_RX_SPEECH_GOOD, 2'h1, 10'd159, ~pat);
    chk_ul(~pat & msk(159), 10'd159, 2'h1, 1'b1);
    foreach (sl[i])
    begin
      frm(sl[i], 2'h3, 10'd35, pat);
      chk_ul(pat & msk(35), 10'd0, 2'h1, 1'b1);
    end
    foreach (zl[i])
    begin
      frm(zl[i], (i == 0) ? 2'h1 : 2'h3, 10'd100, pat);
      chk_ul('0, 10'd0, 2'h1, 1'b1);
    end
    chk32(rats_enable, 1'b0);
    axi_rd(`TCL_OFS_CODEC);
    chk32(d, 32'h5);
    axi_wr(`TCL_OFS_CTRL, 32'hd);
    $display("test adaptive full rate done");
    close_loop(2'h0, 3'h4, 1'b1);
    frm(tcl_pkg::TCL_RX_SPEECH_GOOD, 2'h0, 10'd95, pat);
    chk_ul(pat & msk(95), 10'd95, 2'h0, 1'b1);
    foreach (sl[i])
    begin
      frm(sl[i], 2'h2, 10'd35, ~pat);
      chk_ul('0, 10'd0, 2'h0, 1'b1);
      chk_ul(~pat & msk(35), 10'd0, 2'h0, 1'b1);
    end
    for (int i = 3; i < 5; i++)
    begin
      frm(zl[i], 2'h2, 10'd100, pat);
      chk_ul('0, 10'd0, 2'h0, 1'b1);
      chk_ul('0, 10'd0, 2'h0, 1'b1);
    end
    frm(tcl_pkg::TCL_RX_SID_FIRST_P2, 2'h2, 10'd100, pat);
    frm(tcl_pkg::TCL_RX_SID_INH, 2'h2, 10'd100, pat);
    chk_ul('0, 10'd0, 2'h0, 1'b1);
    chk_ul('0, 10'd0, 2'h0, 1'b1);
    chk32(ulq.size(), 0);
    axi_wr(`TCL_OFS_CTRL, 32'hd);
    $display("test adaptive half rate done");
    close_loop(2'h1, 3'h0, 1'b1);
    src.send_burst(pat[113:0], 1'b0, 1'b0);
    src.send_burst(~pat[113:0], 1'b1, 1'b0);
    src.send_burst(pat[119:6], 1'b0, 1'b1);
    repeat (3) @(posedge aclk);
    chk_b(pat[113:0]);
    chk32(bq.size(), 0);
    axi_rd(`TCL_OFS_STATUS);
    chk32(d, 32'h540);
    axi_wr(`TCL_OFS_CTRL, 32'h1);
    repeat (3) @(posedge aclk);
    axi_rd(`TCL_OFS_STATUS);
    chk32({loop_closed, d[30:0]}, 32'h510);
    $display("test burst loop done");
    report_and_stop();
  end
endmodule : testbench
